//--- design/asrp_readout.sv
// Purpose: Conversion sequencing and serial readout of a 16-bit converter
// Assumes: Host drives convert, shift clock and chain input; sample arrives as a bus
// Notes:   Output enable is low while the serial output is driven
// Notes on behaviour
// - Convert rise starts conversion, latches mode
// - Chain input low at rise: chain mode
// - Chain input high at rise: select mode
// - Select mode drives only while a select low
// - Select low at finish enables busy indicator
// - Chain input reappears after sixteen shift clocks
// - Result shifted one bit per shift clock after the busy high retiring clock, if any
// - Result is two's complement
// - Input held shortly after convert rise
// - Bit fifteen presented first when selected, or next after the busy high when enabled
// - Select mode releases output on select high or last
// - Conversion needs no shift clock activity
module asrp_readout (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        convertStart,
  input  wire logic        serialChainIn,
  input  wire logic        shiftClk,
  input  wire logic [15:0] sampleIn,
  output logic             serialResultOut,
  output logic             serialResultOe_n,
  output logic             busy,
  output logic [15:0]      lastResult
);
  asrp_sync_if sy ();

  asrp_pin_sync u_sync (
    .clk           (clk),
    .reset         (reset),
    .convertStart  (convertStart),
    .serialChainIn (serialChainIn),
    .shiftClk      (shiftClk),
    .sy            (sy)
  );

  asrp_pkg::asrp_state_e state_ff, nxt_state;
  asrp_pkg::asrp_mode_e  mode_ff, nxt_mode;
  logic [6:0]  convCnt_ff, nxt_convCnt;
  logic [15:0] shReg_ff, nxt_shReg;
  logic [4:0]  bitCnt_ff, nxt_bitCnt;
  logic        busyInd_ff, nxt_busyInd;
  logic        sdo_ff, nxt_sdo;
  logic        oeN_ff, nxt_oeN;
  logic        busy_ff, nxt_busy;
  logic [15:0] res_ff, nxt_res;
  logic        selLow;

  // Signed code passes straight through; no offset binary conversion
  function automatic logic [15:0] to_twos(input logic [15:0] s);
    to_twos = s;
  endfunction

  assign selLow = ~sy.convLevel | ~sy.chainLevel;

  always_comb begin
    nxt_state   = state_ff;
    nxt_mode    = mode_ff;
    nxt_convCnt = convCnt_ff;
    nxt_shReg   = shReg_ff;
    nxt_bitCnt  = bitCnt_ff;
    nxt_busyInd = busyInd_ff;
    nxt_sdo     = sdo_ff;
    nxt_oeN     = oeN_ff;
    nxt_busy    = busy_ff;
    nxt_res     = res_ff;
    if (sy.convRise) begin
      // Chain level sampled at the same edge picks the mode
      nxt_mode    = sy.chainLevel ? asrp_pkg::ASRP_SELECT : asrp_pkg::ASRP_CHAIN;
      nxt_state   = asrp_pkg::ASRP_CONV;
      nxt_convCnt = asrp_pkg::CONVCNT_RESET;
      nxt_busy    = 1'b1;
      nxt_busyInd = 1'b0;
      nxt_bitCnt  = asrp_pkg::BITCNT_RESET;
    end else begin
      case (state_ff)
        asrp_pkg::ASRP_IDLE: begin
        end
        asrp_pkg::ASRP_CONV: begin
          // Counts only the system clock; shift clock may be idle
          nxt_convCnt = convCnt_ff + 7'h01;
          if (convCnt_ff == 7'(asrp_pkg::APERTURE_CYC)) begin
            nxt_res = to_twos(sampleIn);
          end
          if (convCnt_ff == 7'(asrp_pkg::CONV_CYCLES - 1)) begin
            nxt_state   = asrp_pkg::ASRP_DONE;
            nxt_busy    = 1'b0;
            nxt_shReg   = res_ff;
            nxt_busyInd = (mode_ff == asrp_pkg::ASRP_SELECT) & selLow;
          end
        end
        asrp_pkg::ASRP_DONE: begin
          if (sy.shiftFall && busyInd_ff) begin
            // First fall only retires the busy high, so bit fifteen keeps a full cycle
            nxt_busyInd = 1'b0;
          end else if (sy.shiftFall && (mode_ff == asrp_pkg::ASRP_CHAIN
                                        || bitCnt_ff != 5'(asrp_pkg::RES_BITS))) begin
            // Shift on falling edge; chain data enters at the bottom
            // Chain mode keeps shifting past sixteen so upstream data passes through
            nxt_shReg = {shReg_ff[14:0], sy.chainLevel};
            if (bitCnt_ff != 5'(asrp_pkg::RES_BITS)) begin
              nxt_bitCnt = bitCnt_ff + 5'h01;
            end
          end
        end
        default: nxt_state = asrp_pkg::ASRP_IDLE;
      endcase
    end
    if (mode_ff == asrp_pkg::ASRP_SELECT) begin
      if (state_ff == asrp_pkg::ASRP_CONV && !sy.convRise) begin
        // Busy indicator: low while converting when enabled
        nxt_sdo = 1'b0;
        nxt_oeN = ~selLow;
      end else if (state_ff == asrp_pkg::ASRP_DONE) begin
        nxt_sdo = busyInd_ff ? 1'b1 : shReg_ff[15];
        nxt_oeN = ~selLow | (bitCnt_ff == 5'(asrp_pkg::RES_BITS));
      end else begin
        nxt_oeN = 1'b1;
      end
    end else begin
      // Chain mode: output always driven; host samples while convert high
      nxt_oeN = 1'b0;
      nxt_sdo = (state_ff == asrp_pkg::ASRP_DONE) ? shReg_ff[15] : 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff   <= asrp_pkg::ASRP_IDLE;
      mode_ff    <= asrp_pkg::ASRP_SELECT;
      convCnt_ff <= asrp_pkg::CONVCNT_RESET;
      shReg_ff   <= asrp_pkg::RESULT_RESET;
      bitCnt_ff  <= asrp_pkg::BITCNT_RESET;
      busyInd_ff <= 1'b0;
      sdo_ff     <= 1'b0;
      oeN_ff     <= 1'b1;
      busy_ff    <= 1'b0;
      res_ff     <= asrp_pkg::RESULT_RESET;
    end else begin
      state_ff   <= nxt_state;
      mode_ff    <= nxt_mode;
      convCnt_ff <= nxt_convCnt;
      shReg_ff   <= nxt_shReg;
      bitCnt_ff  <= nxt_bitCnt;
      busyInd_ff <= nxt_busyInd;
      sdo_ff     <= nxt_sdo;
      oeN_ff     <= nxt_oeN;
      busy_ff    <= nxt_busy;
      res_ff     <= nxt_res;
    end
  end

  assign serialResultOut  = sdo_ff;
  assign serialResultOe_n = oeN_ff;
  assign busy             = busy_ff;
  assign lastResult       = res_ff;

  localparam int CONV_LAT = asrp_pkg::CONV_CYCLES;

  property p_startConv;
    @(posedge clk) disable iff (reset) sy.convRise |=> state_ff == asrp_pkg::ASRP_CONV;
  endproperty
  a_startConv: assert property (p_startConv) else $error("No conversion start");

  property p_chainMode;
    @(posedge clk) disable iff (reset)
      sy.convRise && !sy.chainLevel |=> mode_ff == asrp_pkg::ASRP_CHAIN;
  endproperty
  a_chainMode: assert property (p_chainMode) else $error("Chain mode not latched");

  property p_selMode;
    @(posedge clk) disable iff (reset)
      sy.convRise && sy.chainLevel |=> mode_ff == asrp_pkg::ASRP_SELECT;
  endproperty
  a_selMode: assert property (p_selMode) else $error("Select mode not latched");

  property p_selDrive;
    @(posedge clk) disable iff (reset)
      mode_ff == asrp_pkg::ASRP_SELECT && !selLow |=> oeN_ff;
  endproperty
  a_selDrive: assert property (p_selDrive) else $error("Driven while deselected");

  sequence s_convRun;
    sy.convRise ##1 (state_ff == asrp_pkg::ASRP_CONV && !sy.convRise)[*8];
  endsequence
  property p_busyHold;
    @(posedge clk) disable iff (reset) s_convRun |-> busy_ff;
  endproperty
  a_busyHold: assert property (p_busyHold) else $error("Busy dropped early");

  property p_convEnd;
    @(posedge clk) disable iff (reset)
      $rose(busy_ff) |-> ##[1:CONV_LAT] !busy_ff || sy.convRise;
  endproperty
  a_convEnd: assert property (p_convEnd) else $error("Conversion overran");

  property p_msbFirst;
    @(posedge clk) disable iff (reset)
      state_ff == asrp_pkg::ASRP_DONE && !busyInd_ff && !sy.convRise
        |=> sdo_ff == $past(shReg_ff[15]) || mode_ff == asrp_pkg::ASRP_CHAIN;
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("Wrong bit presented");

  property p_busyLow;
    @(posedge clk) disable iff (reset)
      mode_ff == asrp_pkg::ASRP_SELECT && state_ff == asrp_pkg::ASRP_CONV && !sy.convRise
        |=> !sdo_ff;
  endproperty
  a_busyLow: assert property (p_busyLow) else $error("Busy level not low");

  property p_shiftCount;
    @(posedge clk) disable iff (reset) bitCnt_ff <= 5'(asrp_pkg::RES_BITS);
  endproperty
  a_shiftCount: assert property (p_shiftCount) else $error("Shift count overrun");

  property p_busyRetire;
    @(posedge clk) disable iff (reset)
      state_ff == asrp_pkg::ASRP_DONE && busyInd_ff && sy.shiftFall && !sy.convRise
        |=> !busyInd_ff && bitCnt_ff == asrp_pkg::BITCNT_RESET;
  endproperty
  a_busyRetire: assert property (p_busyRetire) else $error("Busy high not retired");

  property p_chainPass;
    @(posedge clk) disable iff (reset)
      state_ff == asrp_pkg::ASRP_DONE && mode_ff == asrp_pkg::ASRP_CHAIN
        && sy.shiftFall && !sy.convRise
        |=> shReg_ff[0] == $past(sy.chainLevel);
  endproperty
  a_chainPass: assert property (p_chainPass) else $error("Chain data not taken");
endmodule

//--- design/asrp_pkg.sv
// Purpose: Shared constants and types for the serial readout port
// Assumes: 20 MHz system clock
// Notes:   Times in ns, cycle counts derived from the clock rate
package asrp_pkg;
  localparam int          CLK_MHZ       = 20;
  localparam int          RES_BITS      = 16;
  localparam int          CHAIN_DELAY   = 16;
  localparam int          T_CONV_MAX_NS = 1600;
  localparam int          CONV_CYCLES   = (T_CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int          APERTURE_CYC  = 1;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [4:0]  BITCNT_RESET  = 5'h00;
  localparam logic [6:0]  CONVCNT_RESET = 7'h00;

  typedef enum logic [1:0] {
    ASRP_IDLE = 2'b00,
    ASRP_CONV = 2'b01,
    ASRP_DONE = 2'b10
  } asrp_state_e;

  typedef enum logic {
    ASRP_CHAIN  = 1'b0,
    ASRP_SELECT = 1'b1
  } asrp_mode_e;
endpackage

//--- design/asrp_sync_if.sv
// Purpose: Synchronised pin levels and edges between sync stage and core
// Assumes: One clock domain
// Notes:   Edge flags are one-cycle pulses
interface asrp_sync_if;
  logic convLevel;
  logic convRise;
  logic chainLevel;
  logic shiftRise;
  logic shiftFall;
  modport src (output convLevel, convRise, chainLevel, shiftRise, shiftFall);
  modport dst (input convLevel, convRise, chainLevel, shiftRise, shiftFall);
endinterface

//--- design/asrp_pin_sync.sv
// Purpose: Two-flop synchronisers and edge detection for the host pins
// Assumes: Pins come from outside the clock domain
// Notes:   Edge detectors look only at second stage and later
module asrp_pin_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic convertStart,
  input  wire logic serialChainIn,
  input  wire logic shiftClk,
  asrp_sync_if.src  sy
);
  logic [2:0] convPipe_ff, nxt_convPipe;
  logic [1:0] chainPipe_ff, nxt_chainPipe;
  logic [2:0] sckPipe_ff, nxt_sckPipe;

  always_comb begin
    nxt_convPipe  = {convPipe_ff[1:0], convertStart};
    nxt_chainPipe = {chainPipe_ff[0], serialChainIn};
    nxt_sckPipe   = {sckPipe_ff[1:0], shiftClk};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      convPipe_ff  <= 3'h0;
      chainPipe_ff <= 2'h0;
      sckPipe_ff   <= 3'h0;
    end else begin
      convPipe_ff  <= nxt_convPipe;
      chainPipe_ff <= nxt_chainPipe;
      sckPipe_ff   <= nxt_sckPipe;
    end
  end

  assign sy.convLevel  = convPipe_ff[1];
  assign sy.convRise   = convPipe_ff[1] & ~convPipe_ff[2];
  assign sy.chainLevel = chainPipe_ff[1];
  assign sy.shiftRise  = sckPipe_ff[1] & ~sckPipe_ff[2];
  assign sy.shiftFall  = ~sckPipe_ff[1] & sckPipe_ff[2];
endmodule

//--- bench/asrp_host_model.sv
// Purpose: Host controller model driving convert, chain input and shift clock
// Assumes: Shift clock idles low and stands still outside frames
// Notes:   Samples the pin at each shift rise and reports it with a strobe
module asrp_host_model (
  input  wire logic clk,
  input  wire logic pinOut,
  input  wire logic pinOe_n,
  output logic      convertStart,
  output logic      serialChainIn,
  output logic      shiftClk,
  output logic      sampleStrobe,
  output logic      sampledBit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lastDriven;
  logic pinLevel;
  initial begin
    {convertStart, serialChainIn, shiftClk, sampleStrobe, sampledBit, lastDriven} = '0;
  end
  always @(pinOut or pinOe_n) begin
    if (pinOe_n === 1'b0) lastDriven = pinOut;
  end
  // Released pin reads inverted so a stale bit never passes
  assign pinLevel = (pinOe_n === 1'b0) ? pinOut : ~lastDriven;
  task automatic startConv(input logic selMode);
    @(negedge clk);
    convertStart = 1'b0;
    serialChainIn = selMode;
    repeat (3) @(negedge clk);
    convertStart = 1'b1;
  endtask
  // Edges sit on system clock falling edges, like all other bench stimulus
  task automatic shift(input int n, input logic [31:0] chainBits);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge clk);
      shiftClk = 1'b1;
      sampledBit = pinLevel;
      sampleStrobe = 1'b1;
      serialChainIn = chainBits[i];
      repeat (4) @(negedge clk);
      shiftClk = 1'b0;
      sampleStrobe = 1'b0;
    end
  endtask
endmodule

//--- bench/adc_serial_readout_port_test.sv
// Purpose: Self-checking bench for the serial readout port
// Assumes: Host model drives the pins, bench drives the sample bus
// Notes:   Expected bits are queued and compared at each host sample
module adc_serial_readout_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, convertStart, serialChainIn, shiftClk;
  logic        sampleStrobe, sampledBit, serialResultOut, serialResultOe_n, busy;
  logic [15:0] sampleIn, lastResult, code;
  logic [15:0] codes[5];
  logic [31:0] chainBits;
  logic        expQ[$];
  int          errors, tests_run, seed, cnt;

  asrp_readout dut_u (.clk(clk), .reset(reset), .convertStart(convertStart),
    .serialChainIn(serialChainIn), .shiftClk(shiftClk), .sampleIn(sampleIn),
    .serialResultOut(serialResultOut), .serialResultOe_n(serialResultOe_n),
    .busy(busy), .lastResult(lastResult));
  asrp_host_model host_u (.clk(clk), .pinOut(serialResultOut), .pinOe_n(serialResultOe_n),
    .convertStart(convertStart), .serialChainIn(serialChainIn), .shiftClk(shiftClk),
    .sampleStrobe(sampleStrobe), .sampledBit(sampledBit));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic ok);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t output mismatch", $time);
    end
  endtask

  task automatic results();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic waitBusy(input logic lvl);
    for (int n = 0; busy !== lvl; n++) begin
      if (n > 200) begin
        errors++;
        results();
      end
      @(negedge clk);
    end
  endtask

  // Each sampled bit takes the oldest expectation
  always @(posedge sampleStrobe) begin
    tests_run++;
    if (expQ.size() == 0 || sampledBit !== expQ.pop_front()) begin
      errors++;
      $display("[ERR] %0t serial bit mismatch", $time);
    end
  end

  // Conversion length must not depend on shift clock activity
  always @(negedge clk) begin
    if (busy === 1'b1) cnt++;
    else if (cnt != 0) begin
      check(cnt == asrp_pkg::CONV_CYCLES);
      cnt = 0;
    end
  end

  task automatic readSel(input logic [15:0] c);
    sampleIn = c;
    host_u.startConv(1'b1);
    waitBusy(1'b1);
    repeat (3) @(negedge clk);
    sampleIn = ~c;
    waitBusy(1'b0);
    check(serialResultOe_n === 1'b1);
    check(lastResult === c);
    host_u.convertStart = 1'b0;
    repeat (6) @(negedge clk);
    check(serialResultOe_n === 1'b0);
    for (int i = 15; i >= 0; i--) expQ.push_back(c[i]);
    host_u.shift(16, '1);
    repeat (6) @(negedge clk);
    check(serialResultOe_n === 1'b1);
  endtask

  initial begin
    seed = 32'hea46;
    errors = 0;
    tests_run = 0;
    cnt = 0;
    sampleIn = 16'h0000;
    reset = 1'b1;
    codes = '{16'h8000, 16'h7fff, 16'h0000, 16'hffff, 16'h0001};
    repeat (5) @(negedge clk);
    reset = 1'b0;
    check(serialResultOe_n === 1'b1 && busy === 1'b0);
    foreach (codes[k]) readSel(codes[k]);
    code = 16'($random(seed));
    sampleIn = code;
    host_u.startConv(1'b1);
    waitBusy(1'b1);
    host_u.convertStart = 1'b0;
    repeat (6) @(negedge clk);
    check(serialResultOe_n === 1'b0 && serialResultOut === 1'b0);
    waitBusy(1'b0);
    @(negedge clk);
    check(serialResultOut === 1'b1);
    expQ.push_back(1'b1);
    for (int i = 15; i >= 0; i--) expQ.push_back(code[i]);
    host_u.shift(17, '1);
    repeat (6) @(negedge clk);
    check(serialResultOe_n === 1'b1 && lastResult === code);
    code = 16'($random(seed));
    chainBits = $random(seed);
    sampleIn = code;
    host_u.startConv(1'b0);
    waitBusy(1'b1);
    waitBusy(1'b0);
    check(serialResultOe_n === 1'b0 && lastResult === code);
    for (int i = 15; i >= 0; i--) expQ.push_back(code[i]);
    for (int i = 0; i < 8; i++) expQ.push_back(chainBits[i]);
    host_u.shift(24, chainBits);
    check(expQ.size() == 0);
    results();
  end
endmodule
